// ==== gpbcd_pad_model.sv ====
// pad and far-side model for ports b, c and d
// assumes far-side drive per pin from the bench: {b, c, d}
`timescale 1ns/100ps
module gpbcd_pad_model
(
  // clock for the floating-pin pattern
  input wire logic core_clk,
  // pad drive from the block
  input wire gpbcd_pkg::gpbcd_pin8_t drv_b,
  input wire gpbcd_pkg::gpbcd_pin7_t drv_c,
  input wire gpbcd_pkg::gpbcd_pin8_t drv_d,
  // far-side drivers
  input wire logic [22:0] ext_val,
  input wire logic [22:0] ext_en,
  // resolved pad levels
  output logic [7:0] lvl_b,
  output logic [6:0] lvl_c,
  output logic [7:0] lvl_d
);
  logic flt_r = 1'b0;
  logic [22:0] oe;
  logic [22:0] pu;
  // an undriven, unpulled pad wanders every cycle
  always @(posedge core_clk) flt_r <= ~flt_r;
  // block drive wins, then the far side, then the pullup
  assign oe = {drv_b.oe, drv_c.oe, drv_d.oe};
  assign pu = {drv_b.pu, drv_c.pu, drv_d.pu};
  assign {lvl_b, lvl_c, lvl_d} = (oe & {drv_b.out, drv_c.out, drv_d.out})
    | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pu | {23{flt_r}}));
endmodule

// ==== gpbcd_pkg.sv ====
// package for the port b/c/d general-purpose i/o block
// assumes a 32-bit avalon-mm register bus with byte addresses
package gpbcd_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_PORT_B_VALUE = 6'h01;
  localparam logic [5:0] IDX_PORT_C_VALUE = 6'h02;
  localparam logic [5:0] IDX_PORT_D_VALUE = 6'h03;
  localparam logic [5:0] IDX_PORT_B_DIRECTION = 6'h05;
  localparam logic [5:0] IDX_PORT_C_DIRECTION = 6'h06;
  localparam logic [5:0] IDX_PORT_D_DIRECTION = 6'h07;
  localparam logic [5:0] IDX_PORT_C_PULLUP_ENABLE = 6'h0C;
  localparam logic [5:0] IDX_PORT_D_PULLUP_ENABLE = 6'h0D;
  localparam logic [5:0] IDX_PIN_OWNER_CTRL = 6'h10;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // pin owner control field positions
  localparam int CTRL_CAN_PIN_ENABLE = 0;
  localparam int CTRL_SPI_ENABLE_BIT = 1;
  localparam int CTRL_SPI_MASTER_SELECT = 2;
  localparam int CTRL_ELS_LSB = 4;
  localparam int CTRL_ELS_W = 8;

  // port d and port c pin positions shared with peripherals
  localparam int PD_SLAVE_SELECT = 0;
  localparam int PD_SPI_LAST = 3;
  localparam int PD_TIMER_FIRST = 4;
  localparam int PC_CAN_TX = 0;
  localparam int PC_CAN_RX = 1;

  // reset values of control state
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [6:0] DIR_C_RESET = 7'h00;
  localparam logic [7:0] PUE_RESET = 8'h00;
  localparam logic [6:0] PUE_C_RESET = 7'h00;
  localparam logic [11:0] CTRL_RESET = 12'h000;

  // pin drive bundles
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } gpbcd_pin8_t;

  typedef struct packed {
    logic [6:0] out;
    logic [6:0] oe;
    logic [6:0] pu;
  } gpbcd_pin7_t;

  // drive requested by on-chip peripherals that may own pins
  typedef struct packed {
    logic can_tx;
    logic [7:0] pd_out;
    logic [7:0] pd_oe;
  } gpbcd_periph_t;

  // whole state of the block
  typedef struct packed {
    logic [7:0] dir_b;
    logic [6:0] dir_c;
    logic [7:0] dir_d;
    logic [6:0] pue_c;
    logic [7:0] pue_d;
    logic [11:0] ctrl;
    logic [7:0] lat_b;
    logic [6:0] lat_c;
    logic [7:0] lat_d;
    logic [7:0] meta_b;
    logic [6:0] meta_c;
    logic [7:0] meta_d;
    logic [7:0] sync_b;
    logic [6:0] sync_c;
    logic [7:0] sync_d;
    logic wait_req;
    logic [31:0] rdata;
    gpbcd_pin8_t pin_b;
    gpbcd_pin7_t pin_c;
    gpbcd_pin8_t pin_d;
  } gpbcd_state_t;

endpackage

// ==== gpbcd_ports.sv ====
// port b, c and d general-purpose i/o with avalon-mm register access
// assumes pins and peripheral drive are synchronous inputs; pads resolve out/oe/pu
// assumes one bus clock; every register but pin owner control sits in the low byte of its word

`timescale 1ns/100ps

// What this block does
// R1: reset clears all port b direction bits; pins start as inputs.
// R2: direction 1 turns the output buffer on, 0 turns it off.
// R3: port b value read gives latch for outputs, pin level for inputs.
// R4: data latches take writes in any direction; inputs are unaffected.
// R5: software should load the latch before turning a pin to output.
// R6: reset leaves port c and port d latches untouched.
// R7: port c value read gives latch for outputs, pin level for inputs.
// R8: port c has seven pins; reset makes all of them inputs.
// R9: port c pullup enable connects the pullup while the pad is undriven.
// R10: port c pullup drops whenever the pad is driven, by direction or by can.
// R11: can pin enable hands port c bits 1 and 0 to the can module.
// R12: timer 2 edge/level select hands port d bits 7 and 6 to the timer.
// R13: timer 1 edge/level select hands its port d channel pins to the timer.
// R14: with spi disabled, spi clock, mosi and miso pins are plain port pins.
// R15: spi-owned pins ignore direction for drive, but direction still picks read source.
// R16: slave select is a port pin when spi is off or master.
// R17: port d value read gives latch for outputs, pin level for inputs.
// R18: reset clears all port d direction bits.
// R19: port d pullups act only on undriven pads and drop on driven ones, owned pins included.
// R20: pin levels pass two synchroniser flops before reaching read data.
module gpbcd_ports
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [gpbcd_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [gpbcd_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [gpbcd_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // pin levels seen at the pads
  input wire logic [7:0] pin_b_in,
  input wire logic [6:0] pin_c_in,
  input wire logic [7:0] pin_d_in,
  // pad drive
  output gpbcd_pkg::gpbcd_pin8_t pin_b_drv,
  output gpbcd_pkg::gpbcd_pin7_t pin_c_drv,
  output gpbcd_pkg::gpbcd_pin8_t pin_d_drv,
  // peripherals sharing pins
  input wire gpbcd_pkg::gpbcd_periph_t periph_drv,
  output logic [6:0] pin_c_level,
  output logic [7:0] pin_d_level
);

  // whole state, registered in one place
  gpbcd_pkg::gpbcd_state_t state_r;
  gpbcd_pkg::gpbcd_state_t state_nxt;

  // bus decode and write strobes
  logic [5:0] reg_idx;
  logic access_go;
  logic wr_go;
  logic [7:0] wr_byte;
  logic wr_lat_b;
  logic wr_lat_c;
  logic wr_lat_d;
  logic wr_dir_b;
  logic wr_dir_c;
  logic wr_dir_d;
  logic wr_pue_c;
  logic wr_pue_d;
  logic wr_ctrl;
  // pin ownership and drive
  logic can_en;
  logic spi_en;
  logic spi_mstr;
  logic [7:0] own_d;
  logic [7:0] oe_d;
  logic [7:0] out_d;
  logic [6:0] oe_c;
  logic [6:0] out_c;
  // read path
  logic [7:0] rd_b;
  logic [6:0] rd_c;
  logic [7:0] rd_d;
  logic [31:0] rd_word;

  // bus decode: a request is taken on the edge where waitrequest is low
  assign reg_idx = avs_address[7:2];
  assign access_go = (avs_read | avs_write) & ~state_r.wait_req;
  assign wr_go = access_go & avs_write & avs_byteenable[0];
  assign wr_byte = avs_writedata[7:0];

  // one write strobe per register, each only on the taken edge
  assign wr_lat_b = wr_go & (reg_idx == gpbcd_pkg::IDX_PORT_B_VALUE);
  assign wr_lat_c = wr_go & (reg_idx == gpbcd_pkg::IDX_PORT_C_VALUE);
  assign wr_lat_d = wr_go & (reg_idx == gpbcd_pkg::IDX_PORT_D_VALUE);
  assign wr_dir_b = wr_go & (reg_idx == gpbcd_pkg::IDX_PORT_B_DIRECTION);
  assign wr_dir_c = wr_go & (reg_idx == gpbcd_pkg::IDX_PORT_C_DIRECTION);
  assign wr_dir_d = wr_go & (reg_idx == gpbcd_pkg::IDX_PORT_D_DIRECTION);
  assign wr_pue_c = wr_go & (reg_idx == gpbcd_pkg::IDX_PORT_C_PULLUP_ENABLE);
  assign wr_pue_d = wr_go & (reg_idx == gpbcd_pkg::IDX_PORT_D_PULLUP_ENABLE);
  assign wr_ctrl = wr_go & (reg_idx == gpbcd_pkg::IDX_PIN_OWNER_CTRL);

  // pin owner controls
  assign can_en = state_r.ctrl[gpbcd_pkg::CTRL_CAN_PIN_ENABLE];
  assign spi_en = state_r.ctrl[gpbcd_pkg::CTRL_SPI_ENABLE_BIT];
  assign spi_mstr = state_r.ctrl[gpbcd_pkg::CTRL_SPI_MASTER_SELECT];

  // port d ownership per pin
  always_comb
  begin
    own_d = 8'h00;
    // slave select is taken only by an enabled slave
    own_d[gpbcd_pkg::PD_SLAVE_SELECT] = spi_en & ~spi_mstr; // R16
    // spi clock, mosi and miso follow the spi enable alone
    for (int i = 1; i <= gpbcd_pkg::PD_SPI_LAST; i++)
    begin
      own_d[i] = spi_en; // R14
    end
    // each timer channel takes its pin while its select field is nonzero
    for (int t = 0; t < 4; t++)
    begin
      // R12 R13
      own_d[gpbcd_pkg::PD_TIMER_FIRST + t] =
        |state_r.ctrl[gpbcd_pkg::CTRL_ELS_LSB + 2*t +: 2];
    end
  end

  // port d drive: owner peripheral or direction and latch
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (own_d[i])
      begin
        // owned pin: the peripheral decides drive and level
        oe_d[i] = periph_drv.pd_oe[i]; // R15
        out_d[i] = periph_drv.pd_out[i] & periph_drv.pd_oe[i];
      end
      else
      begin
        // plain pin: direction and latch
        oe_d[i] = state_r.dir_d[i]; // R2
        out_d[i] = state_r.lat_d[i] & state_r.dir_d[i];
      end
    end
  end

  // port c drive per pin; can takes bits 1 and 0 when enabled
  for (genvar g = 0; g < 7; g++)
  begin : g_pc_drive
    if (g == gpbcd_pkg::PC_CAN_TX)
    begin : g_tx
      // transmit pin always driven while can owns it
      assign oe_c[g] = can_en | state_r.dir_c[g]; // R11
      assign out_c[g] = can_en ? periph_drv.can_tx : (state_r.lat_c[g] & state_r.dir_c[g]);
    end
    else if (g == gpbcd_pkg::PC_CAN_RX)
    begin : g_rx
      // receive pin never driven while can owns it
      assign oe_c[g] = ~can_en & state_r.dir_c[g]; // R11
      assign out_c[g] = ~can_en & state_r.lat_c[g] & state_r.dir_c[g];
    end
    else
    begin : g_gp
      // remaining pins are plain port pins
      assign oe_c[g] = state_r.dir_c[g]; // R2
      assign out_c[g] = state_r.lat_c[g] & state_r.dir_c[g];
    end
  end

  // value reads: latch for output bits, synchronised pin for input bits
  for (genvar g = 0; g < 8; g++)
  begin : g_rd_src
    assign rd_b[g] = state_r.dir_b[g] ? state_r.lat_b[g] : state_r.sync_b[g]; // R3
    assign rd_d[g] = state_r.dir_d[g] ? state_r.lat_d[g] : state_r.sync_d[g]; // R17 R15
  end

  // port c is one pin short of the others
  for (genvar g = 0; g < 7; g++)
  begin : g_rd_src_c
    assign rd_c[g] = state_r.dir_c[g] ? state_r.lat_c[g] : state_r.sync_c[g]; // R7
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    // value registers first, then direction, pullup and owner control
    case (reg_idx)
      gpbcd_pkg::IDX_PORT_B_VALUE: rd_word[7:0] = rd_b;
      gpbcd_pkg::IDX_PORT_C_VALUE: rd_word[6:0] = rd_c;
      gpbcd_pkg::IDX_PORT_D_VALUE: rd_word[7:0] = rd_d;
      gpbcd_pkg::IDX_PORT_B_DIRECTION: rd_word[7:0] = state_r.dir_b;
      gpbcd_pkg::IDX_PORT_C_DIRECTION: rd_word[6:0] = state_r.dir_c;
      gpbcd_pkg::IDX_PORT_D_DIRECTION: rd_word[7:0] = state_r.dir_d;
      gpbcd_pkg::IDX_PORT_C_PULLUP_ENABLE: rd_word[6:0] = state_r.pue_c;
      gpbcd_pkg::IDX_PORT_D_PULLUP_ENABLE: rd_word[7:0] = state_r.pue_d;
      gpbcd_pkg::IDX_PIN_OWNER_CTRL: rd_word[11:0] = state_r.ctrl;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // next state
  always_comb
  begin
    state_nxt = state_r;
    // first flop of each pad synchroniser
    state_nxt.meta_b = pin_b_in; // R20
    state_nxt.meta_c = pin_c_in;
    state_nxt.meta_d = pin_d_in;
    // second flop; nothing else reads the first
    state_nxt.sync_b = state_r.meta_b; // R20
    state_nxt.sync_c = state_r.meta_c;
    state_nxt.sync_d = state_r.meta_d;

    // handshake: one wait cycle per request, then it is taken
    if (!state_r.wait_req)
    begin
      state_nxt.wait_req = 1'b1;
    end
    else if (avs_read | avs_write)
    begin
      state_nxt.wait_req = 1'b0;
    end

    // read data captured on the wait edge; it stands until the next request
    if (state_r.wait_req && avs_read)
    begin
      state_nxt.rdata = rd_word;
    end
    else if (state_r.wait_req && avs_write)
    begin
      state_nxt.rdata = 32'h0000_0000;
    end

    // data latch writes, accepted whatever the direction
    if (wr_lat_b)
    begin
      state_nxt.lat_b = wr_byte; // R4
    end
    if (wr_lat_c)
    begin
      state_nxt.lat_c = wr_byte[6:0]; // R4
    end
    if (wr_lat_d)
    begin
      state_nxt.lat_d = wr_byte; // R4
    end
    // direction writes; the pad follows one cycle later
    if (wr_dir_b)
    begin
      state_nxt.dir_b = wr_byte; // R2
    end
    if (wr_dir_c)
    begin
      state_nxt.dir_c = wr_byte[6:0]; // R8
    end
    if (wr_dir_d)
    begin
      state_nxt.dir_d = wr_byte; // R18
    end
    // pullup enables; they act only while a pin is undriven
    if (wr_pue_c)
    begin
      state_nxt.pue_c = wr_byte[6:0]; // R9
    end
    if (wr_pue_d)
    begin
      state_nxt.pue_d = wr_byte; // R19
    end
    // owner control; bit 3 is kept zero, the top lane has its own enable
    if (wr_ctrl && avs_byteenable[1])
    begin
      state_nxt.ctrl[11:8] = avs_writedata[11:8];
    end
    if (wr_ctrl)
    begin
      state_nxt.ctrl[7:0] = {avs_writedata[7:4], 1'b0, avs_writedata[2:0]};
    end

    // port b pads: no pullups on this port
    state_nxt.pin_b.out = state_r.lat_b & state_r.dir_b;
    state_nxt.pin_b.oe = state_r.dir_b; // R2
    state_nxt.pin_b.pu = 8'h00;

    // port c pads: pullups drop wherever the pad is driven
    state_nxt.pin_c.out = out_c;
    state_nxt.pin_c.oe = oe_c;
    state_nxt.pin_c.pu = state_r.pue_c & ~oe_c; // R9 R10

    // port d pads: same pullup rule, owned pins included
    state_nxt.pin_d.out = out_d;
    state_nxt.pin_d.oe = oe_d;
    state_nxt.pin_d.pu = state_r.pue_d & ~oe_d; // R19
  end

  // state register; data latches keep their contents through reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // directions, pullups and owner control to idle
      state_r.dir_b <= gpbcd_pkg::DIR_RESET; // R1
      state_r.dir_c <= gpbcd_pkg::DIR_C_RESET; // R8
      state_r.dir_d <= gpbcd_pkg::DIR_RESET; // R18
      state_r.pue_c <= gpbcd_pkg::PUE_C_RESET;
      state_r.pue_d <= gpbcd_pkg::PUE_RESET;
      state_r.ctrl <= gpbcd_pkg::CTRL_RESET;
      // synchroniser flops cleared
      state_r.meta_b <= 8'h00;
      state_r.meta_c <= 7'h00;
      state_r.meta_d <= 8'h00;
      state_r.sync_b <= 8'h00;
      state_r.sync_c <= 7'h00;
      state_r.sync_d <= 8'h00;
      // handshake idle and pads released
      state_r.wait_req <= 1'b1;
      state_r.rdata <= 32'h0000_0000;
      state_r.pin_b <= '0;
      state_r.pin_c <= '0;
      state_r.pin_d <= '0;
    end
    else
    begin
      // latches move on from the next state only
      state_r <= state_nxt; // R6
    end
  end

  // bus answer straight from the state register
  assign avs_readdata = state_r.rdata;
  assign avs_waitrequest = state_r.wait_req;

  // pad drive straight from the state register
  assign pin_b_drv = state_r.pin_b;
  assign pin_c_drv = state_r.pin_c;
  assign pin_d_drv = state_r.pin_d;

  // synchronised levels for peripherals that listen on shared pins
  assign pin_c_level = state_r.sync_c;
  assign pin_d_level = state_r.sync_d;

endmodule

// ==== gpbcd_ports_sva.sv ====
// checker for the port b/c/d i/o block, seeing only its ports
// assumes it is bound to gpbcd_ports from the bench top file
`timescale 1ns/100ps
module gpbcd_ports_sva
(
  // clock, reset and register bus
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // pads
  input wire logic [6:0] pin_c_in,
  input wire gpbcd_pkg::gpbcd_pin8_t pin_b_drv,
  input wire gpbcd_pkg::gpbcd_pin7_t pin_c_drv,
  input wire gpbcd_pkg::gpbcd_pin8_t pin_d_drv,
  input wire logic [6:0] pin_c_level
);
  // all checks run on the bus clock, quiet in reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_reset_quiet: assert property ($rose(rst_n) |-> {pin_b_drv.oe, pin_c_drv.oe, pin_d_drv.oe} == 23'h0)
    else $error("pads driven right after reset");
  a_dir_b_drive: assert property (avs_write && !avs_waitrequest && avs_byteenable[0]
    && avs_address[7:2] == gpbcd_pkg::IDX_PORT_B_DIRECTION
    |-> ##2 pin_b_drv.oe == $past(avs_writedata[7:0], 2))
    else $error("port b buffers do not follow direction write");
  a_dir_b_hold: assert property (!$stable(pin_b_drv.oe) |-> $past(avs_write && !avs_waitrequest
    && avs_address[7:2] == gpbcd_pkg::IDX_PORT_B_DIRECTION, 2))
    else $error("port b buffers changed without a write");
  a_c_pullup_off: assert property ((pin_c_drv.pu & pin_c_drv.oe) == 7'h00)
    else $error("port c pullup on a driven pin");
  a_d_pullup_off: assert property ((pin_d_drv.pu & pin_d_drv.oe) == 8'h00)
    else $error("port d pullup on a driven pin");
  a_d_out_masked: assert property ((pin_d_drv.out & ~pin_d_drv.oe) == 8'h00)
    else $error("port d level on an undriven pin");
  a_c_level_sync: assert property ($past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n)
    |-> pin_c_level == $past(pin_c_in, 2))
    else $error("port c level not two cycles behind pad");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one wait cycle");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[7:2] == 6'h00
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
endmodule

// ==== gpbcd_ports_test.sv ====
// self-checking bench for the port b/c/d i/o block
// assumes gpbcd_pkg, the pad model and the checker are compiled first
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
$display("wrong value at %0t: got %0h want %0h", $time, g, e); end end
module gpbcd_ports_test;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] pin_b_in;
  logic [6:0] pin_c_in;
  logic [7:0] pin_d_in;
  gpbcd_pkg::gpbcd_pin8_t pin_b_drv;
  gpbcd_pkg::gpbcd_pin7_t pin_c_drv;
  gpbcd_pkg::gpbcd_pin8_t pin_d_drv;
  logic [7:0] pin_d_level;
  gpbcd_pkg::gpbcd_periph_t periph_drv = '0;
  logic [22:0] ext_val = 23'h0;
  logic [22:0] ext_en = 23'h7FFFFF;
  logic [31:0] rd;
  int checks = 0;
  int n_mismatch = 0;
  // 100 MHz bus clock
  always #5 core_clk = ~core_clk;
  // block and its pads
  gpbcd_ports u_gpbcd_ports (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_b_in(pin_b_in), .pin_c_in(pin_c_in), .pin_d_in(pin_d_in), .pin_b_drv(pin_b_drv),
    .pin_c_drv(pin_c_drv), .pin_d_drv(pin_d_drv), .periph_drv(periph_drv),
    .pin_c_level(), .pin_d_level(pin_d_level));
  gpbcd_pad_model u_gpbcd_pad_model (.core_clk(core_clk), .drv_b(pin_b_drv),
    .drv_c(pin_c_drv), .drv_d(pin_d_drv), .ext_val(ext_val), .ext_en(ext_en),
    .lvl_b(pin_b_in), .lvl_c(pin_c_in), .lvl_d(pin_d_in));
  // print counts and verdict, then stop
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // one bus access held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
    if (n >= 50)
    begin
      n_mismatch++;
      summarize();
    end
  endtask
  // directions clear after reset, unmapped reads zero
  task automatic t_reset();
    for (int i = 5; i < 8; i++)
    begin
      bus(1'b0, 6'(i), 32'h0);
      `CHK(rd, 32'h0)
    end
    bus(1'b0, 6'h00, 32'h0);
    `CHK(rd, 32'h0)
  endtask
  // port b: latch written as input, then turned to output
  task automatic t_port_b();
    ext_val[22:15] <= 8'h3C;
    bus(1'b1, gpbcd_pkg::IDX_PORT_B_VALUE, 32'hA5);
    tick(3);
    bus(1'b0, gpbcd_pkg::IDX_PORT_B_VALUE, 32'h0);
    `CHK(rd, 32'h3C)
    bus(1'b1, gpbcd_pkg::IDX_PORT_B_DIRECTION, 32'h0F);
    tick(3);
    `CHK(pin_b_drv.oe, 8'h0F)
    `CHK(pin_b_drv.out, 8'h05)
    bus(1'b0, gpbcd_pkg::IDX_PORT_B_VALUE, 32'h0);
    `CHK(rd, 32'h35)
  endtask
  // port c: pullups only on inputs, read mixes latch and pad
  task automatic t_port_c();
    ext_en[14:8] <= 7'h00;
    bus(1'b1, gpbcd_pkg::IDX_PORT_C_VALUE, 32'h55);
    bus(1'b1, gpbcd_pkg::IDX_PORT_C_PULLUP_ENABLE, 32'h7F);
    bus(1'b1, gpbcd_pkg::IDX_PORT_C_DIRECTION, 32'h0F);
    tick(3);
    `CHK(pin_c_drv.pu, 7'h70)
    bus(1'b0, gpbcd_pkg::IDX_PORT_C_VALUE, 32'h0);
    `CHK(rd, 32'h75)
  endtask
  // can, spi and timers taking pins over
  task automatic t_owner();
    periph_drv <= '{can_tx: 1'b1, pd_out: 8'hA0, pd_oe: 8'hF0};
    bus(1'b1, gpbcd_pkg::IDX_PORT_D_VALUE, 32'h5A);
    bus(1'b1, gpbcd_pkg::IDX_PORT_D_DIRECTION, 32'hFF);
    bus(1'b1, gpbcd_pkg::IDX_PORT_D_PULLUP_ENABLE, 32'hFF);
    bus(1'b1, gpbcd_pkg::IDX_PIN_OWNER_CTRL, 32'h003);
    tick(1);
    `CHK({pin_c_drv.oe[1:0], pin_c_drv.out[0]}, 3'b011)
    `CHK({pin_d_drv.oe, pin_d_drv.out}, 16'hF050)
    `CHK(pin_d_drv.pu, 8'h0F)
    bus(1'b0, gpbcd_pkg::IDX_PORT_D_VALUE, 32'h0);
    `CHK(rd, 32'h5A)
    bus(1'b1, gpbcd_pkg::IDX_PIN_OWNER_CTRL, 32'h556);
    tick(1);
    `CHK({pin_d_drv.oe, pin_d_drv.out}, 16'hF1A0)
    `CHK(pin_c_drv.oe[1:0], 2'b11)
    bus(1'b1, gpbcd_pkg::IDX_PIN_OWNER_CTRL, 32'h000);
    tick(1);
    `CHK({pin_d_drv.oe, pin_d_drv.out}, 16'hFF5A)
  endtask
  // second reset keeps latches, clears directions
  task automatic t_keep();
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    tick(1);
    `CHK({pin_c_drv.oe, pin_d_drv.oe}, 15'h0)
    bus(1'b1, gpbcd_pkg::IDX_PORT_C_DIRECTION, 32'h7F);
    bus(1'b0, gpbcd_pkg::IDX_PORT_C_VALUE, 32'h0);
    `CHK(rd, 32'h55)
    bus(1'b1, gpbcd_pkg::IDX_PORT_D_DIRECTION, 32'hFF);
    bus(1'b0, gpbcd_pkg::IDX_PORT_D_VALUE, 32'h0);
    `CHK(rd, 32'h5A)
    `CHK(pin_d_level, 8'h5A)
  endtask
  // main sequence
  initial
  begin
    tick(16);
    rst_n <= 1'b1;
    tick(1);
    t_reset();
    t_port_b();
    t_port_c();
    t_owner();
    t_keep();
    summarize();
  end
endmodule
bind gpbcd_ports gpbcd_ports_sva u_gpbcd_ports_sva (.core_clk, .rst_n, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .pin_c_in, .pin_b_drv, .pin_c_drv, .pin_d_drv, .pin_c_level);
